// ==== hw/dpa_pkg.sv ====
// Package: shared constants and types for the switch phase absorb block
package dpa_pkg;
  // ==========================================================
  // Register map (word aligned byte addresses)
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_BIAS    = 8'h04;
  localparam logic [7:0] A_TRIM_LO = 8'h08;
  localparam logic [7:0] A_TRIM_HI = 8'h0c;
  localparam logic [7:0] A_HOLDIN  = 8'h10;
  localparam logic [7:0] A_SLEWDIV = 8'h14;
  localparam logic [7:0] A_STATUS  = 8'h18;
  localparam logic [7:0] A_ABSOFF  = 8'h1c;
  localparam logic [7:0] A_IRQ_STS = 8'h20;
  localparam logic [7:0] A_IRQ_MSK = 8'h24;
  // ==========================================================
  // Field positions
  localparam int CTRL_EN   = 0;
  localparam int CTRL_HOLD = 1;
  localparam int IRQ_ABS   = 0;
  localparam int IRQ_DONE  = 1;
  localparam int IRQ_REJ   = 2;
  localparam int IRQ_W     = 3;
  // ==========================================================
  // Reset values and the hold-in limit
  localparam logic        RST_EN      = 1'b1;
  localparam logic [9:0]  RST_HOLDIN  = 10'h073;
  localparam logic [9:0]  HOLDIN_MAX  = 10'h3e8;
  localparam logic [15:0] RST_SLEWDIV = 16'h0064;
  // ==========================================================
  // Phase scaling, all offsets held in units of the trim step
  localparam int TRIM_STEP_PS  = 6;
  localparam int BIAS_STEP_PS  = 101;
  localparam int BIAS_LSB      = (BIAS_STEP_PS + TRIM_STEP_PS / 2) / TRIM_STEP_PS;
  localparam int BIAS_MAX_PS   = 1400;
  localparam int BIAS_MAX      = BIAS_MAX_PS / BIAS_STEP_PS;
  localparam int TRANSIENT_PS  = 5000;
  localparam int TRANSIENT_LSB = TRANSIENT_PS / TRIM_STEP_PS;
  // ==========================================================
  // Timing
  localparam int CLK_NS      = 10;
  localparam int MEAS_TMO_NS = 2000;
  localparam int MEAS_TMO    = MEAS_TMO_NS / CLK_NS;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ST_TRACK,
    ST_MEASURE
  } dpa_state_t;

  typedef struct packed {
    logic        [7:0]  addr;
    logic        [15:0] wdata;
    logic               wr;
    logic               rd;
  } dpa_bus_req_t;

  typedef struct packed {
    logic               lost;
    logic signed [11:0] freq_off;
    logic signed [15:0] ph_meas;
    logic               ph_valid;
    logic               locked;
  } dpa_ref_t;
endpackage : dpa_pkg

// ==== hw/dpa_phase_absorb.sv ====
// Module: reference switch phase absorption, bias and output phase trim
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps

// Notes on behaviour
// - Lost reference switches source, raises absorb event
// - Absorption exists on main timing path only
// - Event enters holdover, measures new input phase
// - Measured difference loaded as DPLL offset
// - Output transient stays within 5 ns
// - Enable bit resets to enabled
// - Hold bit ignores events, keeps offset
// - Disable drops offset, slews at bandwidth rate
// - Enabling while locked triggers an event
// - Bias 0.101 ns steps, limited 1.4 ns
// - Absorption off steers to zero plus trim
// - Trim 6 ps steps over 200 ns
// - Trim shifts the feedback clock phase
// - 16-bit trim used only when disabled
// - Reject input held outside hold-in range
// - Hold-in defaults 9.2 ppm, max 80
module dpa_phase_absorb
  import dpa_pkg::*;
#(
  parameter bit MAIN_PATH = 1'b1,
  parameter int REJ_CYC   = 1000
) (
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst,
  // Register port
  input  wire dpa_bus_req_t       bus,
  output logic        [15:0]      rdata,
  // Reference monitor side
  input  wire dpa_ref_t           ref_in,
  // DPLL side
  output logic                    switch_req,
  output logic                    holdover,
  output logic signed [15:0]      fb_phase_off,
  // Interrupt
  output logic                    irq
);

  // ==========================================================
  // Elaboration checks
  if (REJ_CYC < 1 || REJ_CYC > 65535) begin : g_bad_rej
    $error("REJ_CYC out of range");
  end
  if (BIAS_MAX * BIAS_LSB >= TRANSIENT_LSB) begin : g_bad_bias
    $error("Bias range exceeds transient budget");
  end

  // ==========================================================
  // State
  typedef struct packed {
    dpa_state_t         st;
    logic               en;
    logic               hold;
    logic signed [4:0]  bias;
    logic        [15:0] trim;
    logic        [9:0]  holdin;
    logic        [15:0] sdiv;
    logic        [15:0] scnt;
    logic signed [15:0] abs_off;
    logic signed [15:0] fb_off;
    logic [IRQ_W-1:0]   ists;
    logic [IRQ_W-1:0]   imsk;
    logic        [15:0] rdata;
    logic               sw;
    logic               hov;
    logic               irq;
    logic        [15:0] rej_cnt;
    logic        [7:0]  tmo;
    logic               lost_d;
  } dpa_regs_t;

  dpa_regs_t q;
  dpa_regs_t d;

  // ==========================================================
  // Helpers
  function automatic logic signed [15:0] sat16(input logic signed [16:0] v);
    if (v > 17'sd32767) begin
      sat16 = 16'sh7fff;
    end else if (v < -17'sd32768) begin
      sat16 = 16'sh8000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction : sat16

  function automatic logic signed [4:0] clamp_bias(input logic signed [4:0] v);
    if (v > 5'(BIAS_MAX)) begin
      clamp_bias = 5'(BIAS_MAX);
    end else if (v < -5'(BIAS_MAX)) begin
      clamp_bias = -5'(BIAS_MAX);
    end else begin
      clamp_bias = v;
    end
  endfunction : clamp_bias

  function automatic logic [11:0] mag12(input logic signed [11:0] v);
    mag12 = v[11] ? 12'(-v) : 12'(v);
  endfunction : mag12

  // ==========================================================
  // Combinational helpers
  logic               en_eff;
  logic               rej_fire;
  logic               ev_switch;
  logic               ev_enable;
  logic               ev_absorb;
  logic               w_ctrl;
  logic               slew_tick;
  logic signed [15:0] bias_ofs;
  logic signed [15:0] load_val;
  logic signed [15:0] target;
  logic [IRQ_W-1:0]   iset;

  // Secondary path instances never absorb
  assign en_eff = q.en & MAIN_PATH;
  assign w_ctrl = bus.wr && bus.addr == A_CTRL;
  // Counted on a clamped bias so an out of range write cannot exceed 1.4 ns
  assign bias_ofs = 16'(q.bias) * 16'(BIAS_LSB);
  assign load_val = sat16(17'(ref_in.ph_meas) + 17'(bias_ofs));
  // Disabled: zero phase error plus the trim, applied on the feedback side
  assign target = en_eff ? q.abs_off : $signed(q.trim);
  assign rej_fire = q.rej_cnt == 16'(REJ_CYC - 1) && mag12(ref_in.freq_off) > 12'(q.holdin);
  assign ev_switch = (ref_in.lost && !q.lost_d) || rej_fire;
  assign ev_enable = w_ctrl && bus.wdata[CTRL_EN] && !q.en && ref_in.locked;
  assign ev_absorb = (ev_switch || ev_enable) && MAIN_PATH && !q.hold;
  assign slew_tick = q.scnt == 16'h0000;

  always_comb begin
    iset = '0;
    iset[IRQ_ABS] = ev_absorb && (en_eff || ev_enable);
    iset[IRQ_DONE] = q.st == ST_MEASURE && ref_in.ph_valid;
    iset[IRQ_REJ] = rej_fire;
  end

  // ==========================================================
  // Next state
  always_comb begin
    d = q;
    d.sw = ev_switch;
    d.lost_d = ref_in.lost;
    // Hold-in dwell counter
    if (mag12(ref_in.freq_off) > 12'(q.holdin) && !rej_fire) begin
      d.rej_cnt = q.rej_cnt + 16'h0001;
    end else begin
      d.rej_cnt = 16'h0000;
    end
    // Bandwidth divider paces the slew
    if (slew_tick) begin
      d.scnt = q.sdiv;
    end else begin
      d.scnt = q.scnt - 16'h0001;
    end
    // Register writes
    if (bus.wr) begin
      if (bus.addr == A_CTRL) begin
        d.en = bus.wdata[CTRL_EN];
        d.hold = bus.wdata[CTRL_HOLD];
      end else if (bus.addr == A_BIAS) begin
        d.bias = clamp_bias(bus.wdata[4:0]);
      end else if (bus.addr == A_TRIM_LO) begin
        d.trim[7:0] = bus.wdata[7:0];
      end else if (bus.addr == A_TRIM_HI) begin
        d.trim[15:8] = bus.wdata[7:0];
      end else if (bus.addr == A_HOLDIN) begin
        // 0.08 ppm steps, limited to 80 ppm
        d.holdin = bus.wdata[9:0] > HOLDIN_MAX ? HOLDIN_MAX : bus.wdata[9:0];
      end else if (bus.addr == A_SLEWDIV) begin
        d.sdiv = bus.wdata;
      end else if (bus.addr == A_IRQ_MSK) begin
        d.imsk = bus.wdata[IRQ_W-1:0];
      end
    end
    // Sticky status: write one clears, a new event wins
    if (bus.wr && bus.addr == A_IRQ_STS) begin
      d.ists = (q.ists & ~bus.wdata[IRQ_W-1:0]) | iset;
    end else begin
      d.ists = q.ists | iset;
    end
    d.irq = |(d.ists & d.imsk);
    // Absorption sequence
    case (q.st)
      ST_TRACK: begin
        if (ev_absorb && (en_eff || ev_enable)) begin
          d.st = ST_MEASURE;
          d.tmo = 8'h00;
        end
      end
      ST_MEASURE: begin
        d.tmo = q.tmo + 8'h01;
        if (ref_in.ph_valid) begin
          d.abs_off = load_val;
          d.st = ST_TRACK;
        end else if (q.tmo == 8'(MEAS_TMO - 1) || !d.en) begin
          // No measurement: on timeout keep the old offset rather than guess; disabling drops it below
          d.st = ST_TRACK;
        end
      end
      default: begin
        d.st = ST_TRACK;
      end
    endcase
    d.hov = d.st == ST_MEASURE;
    // Disabling drops the absorbed offset
    if (!d.en) begin
      d.abs_off = 16'sh0000;
    end
    // Feedback phase: frozen in holdover, step on load, slew otherwise
    if (q.st == ST_MEASURE) begin
      d.fb_off = q.fb_off;
    end else if (en_eff) begin
      d.fb_off = q.abs_off;
    end else if (slew_tick && q.fb_off < target) begin
      d.fb_off = q.fb_off + 16'sh0001;
    end else if (slew_tick && q.fb_off > target) begin
      d.fb_off = q.fb_off - 16'sh0001;
    end
    // Read data, valid only in the cycle after the strobe
    d.rdata = 16'h0000;
    if (bus.rd) begin
      if (bus.addr == A_CTRL) begin
        d.rdata = {14'h0000, q.hold, q.en};
      end else if (bus.addr == A_BIAS) begin
        d.rdata = 16'(q.bias);
      end else if (bus.addr == A_TRIM_LO) begin
        d.rdata = {8'h00, q.trim[7:0]};
      end else if (bus.addr == A_TRIM_HI) begin
        d.rdata = {8'h00, q.trim[15:8]};
      end else if (bus.addr == A_HOLDIN) begin
        d.rdata = {6'h00, q.holdin};
      end else if (bus.addr == A_SLEWDIV) begin
        d.rdata = q.sdiv;
      end else if (bus.addr == A_STATUS) begin
        d.rdata = {13'h0000, ref_in.locked, q.hov, en_eff};
      end else if (bus.addr == A_ABSOFF) begin
        d.rdata = q.abs_off;
      end else if (bus.addr == A_IRQ_STS) begin
        d.rdata = 16'(q.ists);
      end else if (bus.addr == A_IRQ_MSK) begin
        d.rdata = 16'(q.imsk);
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.en <= RST_EN;
      q.holdin <= RST_HOLDIN;
      q.sdiv <= RST_SLEWDIV;
      q.scnt <= RST_SLEWDIV;
    end else begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign switch_req = q.sw;
  assign holdover = q.hov;
  assign fb_phase_off = q.fb_off;
  assign irq = q.irq;

  // ==========================================================
  // Checks
  // Measurement window as a local int so delay bounds stay plain
  localparam int MEAS_CYC = MEAS_TMO;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_switch_pulse: assert property (
    $rose(ref_in.lost) |=> switch_req ##1 !switch_req || ref_in.lost)
    else $error("Loss of reference gave no switch pulse");

  chk_main_only: assert property (
    !MAIN_PATH |-> !holdover)
    else $error("Secondary path entered absorb holdover");

  chk_hold_entry: assert property (
    ev_switch && q.en && !q.hold && MAIN_PATH && q.st == ST_TRACK |=> holdover)
    else $error("Absorb event did not enter holdover");

  chk_offset_load: assert property (
    holdover && ref_in.ph_valid |=> q.abs_off == $past(load_val) ##1 fb_phase_off == $past(load_val, 2))
    else $error("Measured phase not loaded as offset");

  chk_no_jump: assert property (
    holdover ##1 holdover |-> $stable(fb_phase_off))
    else $error("Output phase moved during holdover");

  chk_reset_en: assert property (
    $fell(rst) |-> q.en)
    else $error("Absorb enable not set after reset");

  chk_freeze: assert property (
    q.hold && q.st == ST_TRACK && ev_switch && !w_ctrl |=> !holdover && $stable(q.abs_off))
    else $error("Frozen absorb reacted to a switch");

  chk_slew_step: assert property (
    !q.en && !holdover && !$past(q.en) |-> fb_phase_off - $past(fb_phase_off) inside {-16'sd1, 16'sd0, 16'sd1})
    else $error("Disabled output phase stepped");

  chk_enable_trig: assert property (
    ev_enable && MAIN_PATH && !q.hold && q.st == ST_TRACK |=> holdover ##0 q.ists[IRQ_ABS])
    else $error("Enabling while locked gave no event");

  chk_bias_range: assert property (
    bias_ofs <= 16'(BIAS_MAX * BIAS_LSB) && bias_ofs >= -16'(BIAS_MAX * BIAS_LSB))
    else $error("Bias beyond 1.4 ns");

  chk_trim_unused: assert property (
    q.en && MAIN_PATH && !holdover |=> fb_phase_off == $past(q.abs_off))
    else $error("Trim reached the output while absorbing");

  chk_reject: assert property (
    rej_fire |=> switch_req ##0 q.ists[IRQ_REJ] ##0 q.rej_cnt == 16'h0000)
    else $error("Hold-in violation not rejected");

  chk_holdin_max: assert property (
    q.holdin <= HOLDIN_MAX)
    else $error("Hold-in range above 80 ppm");

  chk_meas_bound: assert property (
    $rose(holdover) |-> ##[1:MEAS_CYC] !holdover)
    else $error("Holdover outlived the measurement window");

  chk_rdata_idle: assert property (
    !$past(bus.rd) |-> rdata == 16'h0000)
    else $error("Read data stood outside its cycle");

  chk_drop_offset: assert property (
    !q.en |-> q.abs_off == 16'sh0000)
    else $error("Absorbed offset kept while disabled");

  chk_hold_keep: assert property (
    q.hold && q.en && !holdover ##1 q.hold && q.en |-> $stable(q.abs_off))
    else $error("Frozen offset changed");

  chk_hold_no_event: assert property (
    q.hold && ev_switch && !w_ctrl && !q.ists[IRQ_ABS] |=> !q.ists[IRQ_ABS])
    else $error("Frozen absorb flagged an event");

  chk_bias_clamp: assert property (
    q.bias <= 5'(BIAS_MAX) && q.bias >= -5'(BIAS_MAX))
    else $error("Bias register beyond its limit");

  chk_slew_pace: assert property (
    !q.en && !holdover && !slew_tick |=> $stable(fb_phase_off))
    else $error("Output phase moved between slew ticks");

  chk_settle_trim: assert property (
    !q.en && !holdover && slew_tick && fb_phase_off != $signed(q.trim) |=> fb_phase_off != $past(fb_phase_off))
    else $error("Output phase did not move toward the trim");

  chk_done_flag: assert property (
    holdover && ref_in.ph_valid |=> q.ists[IRQ_DONE])
    else $error("Measurement done not flagged");

  chk_sec_no_offset: assert property (
    !MAIN_PATH |-> q.abs_off == 16'sh0000)
    else $error("Secondary path holds an absorbed offset");

  chk_irq_level: assert property (
    irq == |(q.ists & q.imsk))
    else $error("Interrupt does not follow masked status");

endmodule : dpa_phase_absorb

// ==== verif/dpa_ref_src.sv ====
// Model of the selected reference sources and their phase measurement
`timescale 1ns/1ps
module dpa_ref_src
  import dpa_pkg::*;
(
  // Clock
  input  wire logic sys_clk,
  // DPLL side
  input  wire logic holdover,
  // Monitor outputs
  output dpa_ref_t  ref_out
);
  int                 resp_dly = 3;
  logic signed [15:0] ph_next  = 16'sh0000;
  int                 cnt      = 0;

  initial ref_out = '0;

  // ==========================================================
  // Measurement answer
  // Answers only while held over; the phase lines scramble when not valid
  always @(posedge sys_clk) begin
    ref_out.ph_valid <= 1'b0;
    ref_out.ph_meas  <= ~ref_out.ph_meas;
    if (holdover === 1'b1 && !ref_out.ph_valid) begin
      cnt <= cnt + 1;
      if (cnt == resp_dly) begin
        ref_out.ph_valid <= 1'b1;
        // Phase steps arrive whole, as with frame-rate lock mode on
        ref_out.ph_meas  <= ph_next;
        cnt              <= 0;
      end
    end else begin
      cnt <= 0;
    end
  end

  task set_ref(input logic lost, input logic signed [11:0] fo, input logic lk);
    @(posedge sys_clk);
    ref_out.lost     <= lost;
    // Offsets change slowly; a wide capture range is taken as engaged
    ref_out.freq_off <= fo;
    ref_out.locked   <= lk;
  endtask : set_ref
endmodule : dpa_ref_src

// ==== verif/testbench.sv ====
// Self-checking testbench for the switch phase absorb block
`timescale 1ns/1ps
module testbench
  import dpa_pkg::*;
;
  logic               sys_clk;
  logic               rst;
  dpa_bus_req_t       bus;
  logic        [15:0] rdata;
  dpa_ref_t           ref_in;
  logic               switch_req;
  logic               holdover;
  logic signed [15:0] fb_phase_off;
  logic               irq;
  logic               sec_hold;
  int                 bad_count = 0;
  int                 cmp_count = 0;

  // ==========================================================
  // Instances
  dpa_phase_absorb #(.MAIN_PATH(1'b1), .REJ_CYC(4)) dut_u (.sys_clk(sys_clk), .rst(rst), .bus(bus),
    .rdata(rdata), .ref_in(ref_in), .switch_req(switch_req), .holdover(holdover),
    .fb_phase_off(fb_phase_off), .irq(irq));
  // Secondary path copy shares every input
  dpa_phase_absorb #(.MAIN_PATH(1'b0), .REJ_CYC(4)) sec_u (.sys_clk(sys_clk), .rst(rst), .bus(bus),
    .rdata(), .ref_in(ref_in), .switch_req(), .holdover(sec_hold), .fb_phase_off(), .irq());
  dpa_ref_src src_u (.sys_clk(sys_clk), .holdover(holdover), .ref_out(ref_in));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Helpers
  task summarize;
    if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  task chk16(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk16

  task chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk1

  task bus_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge sys_clk);
    bus.wr    <= 1'b0;
  endtask : bus_wr

  task bus_rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge sys_clk);
    bus.rd   <= 1'b0;
    #1 d = rdata;
  endtask : bus_rd

  task rd_chk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    bus_rd(a, d);
    chk16(d, exp);
  endtask : rd_chk

  // Raise a loss, look at the answer edge and the edge after
  task loss(input logic exp_hold, input logic [15:0] fb_prev);
    src_u.set_ref(1'b1, 12'sd0, src_u.ref_out.locked);
    @(posedge sys_clk);
    #1;
    chk1(switch_req, 1'b1);
    chk1(holdover, exp_hold);
    chk1(sec_hold, 1'b0);
    chk16(fb_phase_off, fb_prev);
    @(posedge sys_clk);
    #1 chk1(switch_req, 1'b0);
    src_u.set_ref(1'b0, 12'sd0, src_u.ref_out.locked);
  endtask : loss

  task wait_idle;
    for (int i = 0; i < 300 && holdover !== 1'b0; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk1(holdover, 1'b0);
    repeat (3) @(posedge sys_clk);
  endtask : wait_idle

  // ==========================================================
  // Scenarios
  task t_reset;
    rd_chk(A_CTRL, 16'h0001);
    rd_chk(A_HOLDIN, 16'h0073);
    rd_chk(8'h3c, 16'h0000);
    chk16(fb_phase_off, 16'h0000);
  endtask : t_reset

  task t_absorb;
    logic [15:0] bw [3] = '{16'h0003, 16'h0010, 16'h000f};
    logic [15:0] ph [3] = '{16'hffd8, 16'h0000, 16'h0000};
    logic [15:0] ex [3] = '{16'h000b, 16'hff23, 16'h00dd};
    src_u.ph_next = 16'sd100;
    loss(1'b1, 16'h0000);
    wait_idle;
    rd_chk(A_ABSOFF, 16'h0064);
    chk16(fb_phase_off, 16'h0064);
    rd_chk(A_IRQ_STS, 16'h0003);
    src_u.resp_dly = 40;
    for (int i = 0; i < 3; i++) begin
      bus_wr(A_BIAS, bw[i]);
      src_u.ph_next = ph[i];
      loss(1'b1, (i == 0) ? 16'h0064 : ex[i-1]);
      wait_idle;
      rd_chk(A_ABSOFF, ex[i]);
    end
    rd_chk(A_BIAS, 16'h000d);
  endtask : t_absorb

  task t_irq;
    logic a;
    bus_wr(A_IRQ_MSK, 16'h0000);
    repeat (2) @(posedge sys_clk);
    a = irq;
    bus_wr(A_IRQ_MSK, 16'h0007);
    repeat (2) @(posedge sys_clk);
    chk1(a, 1'b0);
    chk1(irq, 1'b1);
    bus_wr(A_IRQ_STS, 16'h0007);
    repeat (2) @(posedge sys_clk);
    chk1(irq, 1'b0);
    rd_chk(A_IRQ_STS, 16'h0000);
  endtask : t_irq

  task t_hold;
    bus_wr(A_CTRL, 16'h0003);
    loss(1'b0, 16'h00dd);
    repeat (20) @(posedge sys_clk);
    chk1(holdover, 1'b0);
    chk16(fb_phase_off, 16'h00dd);
  endtask : t_hold

  task t_trim;
    logic signed [15:0] prev;
    logic signed [15:0] dlt;
    bus_wr(A_CTRL, 16'h0001);
    bus_wr(A_TRIM_LO, 16'h00f0);
    bus_wr(A_TRIM_HI, 16'h00ff);
    rd_chk(A_TRIM_LO, 16'h00f0);
    rd_chk(A_TRIM_HI, 16'h00ff);
    repeat (5) @(posedge sys_clk);
    chk16(fb_phase_off, 16'h00dd);
    bus_wr(A_SLEWDIV, 16'h0001);
    bus_wr(A_CTRL, 16'h0000);
    rd_chk(A_ABSOFF, 16'h0000);
    for (int i = 0; i < 1000 && fb_phase_off !== 16'hfff0; i++) begin
      prev = fb_phase_off;
      @(posedge sys_clk);
      #1 dlt = fb_phase_off - prev;
      chk1(dlt <= 1 && dlt >= -1, 1'b1);
    end
    chk16(fb_phase_off, 16'hfff0);
  endtask : t_trim

  task t_en_locked;
    src_u.set_ref(1'b0, 12'sd0, 1'b1);
    src_u.ph_next = -16'sd5;
    bus_wr(A_IRQ_STS, 16'h0007);
    bus_wr(A_CTRL, 16'h0001);
    for (int i = 0; i < 3 && holdover !== 1'b1; i++) @(posedge sys_clk);
    chk1(holdover, 1'b1);
    wait_idle;
    rd_chk(A_IRQ_STS, 16'h0003);
    rd_chk(A_ABSOFF, 16'h00d8);
    rd_chk(A_STATUS, 16'h0005);
  endtask : t_en_locked

  // No measurement arrives: holdover ends on its window, offset kept
  task t_timeout;
    src_u.resp_dly = 250;
    bus_wr(A_IRQ_STS, 16'h0007);
    loss(1'b1, 16'h00d8);
    repeat (190) @(posedge sys_clk);
    #1 chk1(holdover, 1'b1);
    repeat (10) @(posedge sys_clk);
    #1 chk1(holdover, 1'b0);
    rd_chk(A_ABSOFF, 16'h00d8);
    rd_chk(A_IRQ_STS, 16'h0001);
  endtask : t_timeout

  task t_holdin;
    logic signed [11:0] fo [3] = '{12'sd115, 12'sd116, -12'sd116};
    logic               ex [3] = '{1'b0, 1'b1, 1'b1};
    logic               seen;
    logic        [15:0] d;
    bus_wr(A_HOLDIN, 16'h03ff);
    rd_chk(A_HOLDIN, 16'h03e8);
    bus_wr(A_HOLDIN, 16'h0073);
    bus_wr(A_CTRL, 16'h0003);
    for (int i = 0; i < 3; i++) begin
      bus_wr(A_IRQ_STS, 16'h0007);
      seen = 1'b0;
      src_u.set_ref(1'b0, fo[i], 1'b1);
      repeat (20) begin
        @(posedge sys_clk);
        #1 seen = seen | switch_req;
      end
      src_u.set_ref(1'b0, 12'sd0, 1'b1);
      chk1(seen, ex[i]);
      bus_rd(A_IRQ_STS, d);
      chk1(d[IRQ_REJ], ex[i]);
    end
  endtask : t_holdin

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    rst = 1'b1;
    bus = '0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset;
    t_absorb;
    t_irq;
    t_hold;
    t_trim;
    t_en_locked;
    t_timeout;
    t_holdin;
    summarize;
  end

  initial begin
    #200000;
    bad_count++;
    summarize;
  end
endmodule : testbench
